// *** pkg/dlt_pkg.sv ***
// ---------------------------------------------------------------
// shared constants and carriers of the die link status/trace block
// ---------------------------------------------------------------
package dlt_pkg;

  // register word indices (byte address is four times the index)
  localparam logic [2:0] IDX_ACK_WAIT_CTRL  = 3'h1; // ack wait limit control
  localparam logic [2:0] IDX_ERROR_STATUS   = 3'h2; // link_error_status
  localparam logic [2:0] IDX_BUSY_IRQ       = 3'h3; // link_busy_irq_status
  localparam logic [2:0] IDX_ADDR_TRACE     = 3'h4; // transaction_address_trace
  localparam logic [2:0] IDX_DATA_TRACE     = 3'h5; // transaction_data_trace

  // link_error_status field positions
  localparam int BIT_ERROR_SUMMARY = 7;
  localparam int BIT_ACK_FAULT     = 6;
  localparam int BIT_CANCEL        = 5;
  localparam int BIT_TIMEOUT       = 4;
  localparam int BIT_TARGET_ERROR  = 3;
  localparam int BIT_PARITY_FAULT  = 2;
  localparam int BIT_PARITY_HI     = 1;
  localparam int BIT_PARITY_LO     = 0;

  // link_busy_irq_status field positions
  localparam int BIT_TARGET_IRQ    = 7;
  localparam int BIT_BUSY          = 6;

  // transaction_address_trace field positions
  localparam int BIT_DIRECTION     = 15;
  localparam int BIT_BYTE_SIZE     = 14;
  localparam int BIT_NONBLOCKING   = 12;

  // widths and reset values
  localparam int LIMIT_W           = 4;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [15:0] TRACE_RST  = 16'h0000;
  localparam logic [3:0]  LIMIT_RST  = 4'h0;
  localparam logic [7:0]  ALL_HIGH   = 8'hff;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // events from the transaction sequencer on the bus clock
  typedef struct packed {
    logic        start;     // pulse: a transaction is requested
    logic        rnw;       // 1 read, 0 write
    logic        sz8;       // 1 byte transfer, 0 halfword
    logic        nonblocking_mode_bit;      // 1 non-blocking window
    logic [7:0]  addr;      // window relative address
    logic [15:0] wdata;     // outgoing write data
    logic        last_xfer; // pulse: last transfer cycle sent
    logic        rd_valid;  // pulse: a read byte has arrived
    logic        rd_hi;     // byte lane of the arriving byte
    logic [7:0]  rd_byte;   // arriving read byte
    logic [1:0]  exp_par;   // parity computed by the initiator
  } dlt_seq_evt_s;

  // answer to the transaction sequencer
  typedef struct packed {
    logic hold_idle; // send idle in place of requested transactions
    logic busy;      // a transaction is in progress
    logic done;      // pulse: acknowledge taken or timeout declared
  } dlt_seq_rsp_s;

endpackage

// *** design/dlt_status_trace.sv ***
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module dlt_status_trace (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // avalon-mm slave
  input  wire logic [2:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [3:0]            avs_byteenable,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // transaction sequencer
  input  wire dlt_pkg::dlt_seq_evt_s seq_evt,
  output dlt_pkg::dlt_seq_rsp_s      seq_rsp,
  // link pins, asynchronous to clk
  input  wire logic                  link_clk,
  input  wire logic                  link_ack,
  input  wire logic                  link_err,
  input  wire logic [1:0]            link_par,
  input  wire logic [7:0]            link_data,
  input  wire logic                  target_irq_pin,
  // error interrupt
  output logic                       link_error_interrupt
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [1:0]  lclk_sync_ff;      // link clock synchroniser
  logic        lclk_prev_ff;      // previous synchronised link clock
  logic [1:0]  ack_sync_ff;       // ack line synchroniser
  logic [1:0]  err_sync_ff;       // error line synchroniser
  logic [1:0]  par_meta_ff;       // parity first stage
  logic [1:0]  par_sync_ff;       // parity second stage
  logic [7:0]  data_meta_ff;      // data first stage
  logic [7:0]  data_sync_ff;      // data second stage
  logic [1:0]  irq_sync_ff;       // target irq synchroniser
  logic        wait_ff;           // waitrequest register
  logic [31:0] rdata_ff;          // read data register
  logic [3:0]  limit_ff;          // ack wait limit
  logic        err_sum_ff;        // error summary flag
  logic        ack_fault_ff;      // ack cycle data fault flag
  logic        cancel_ff;         // cancel flag
  logic        timeout_ff;        // ack timeout flag
  logic        terr_ff;           // target error flag
  logic        par_fault_ff;      // parity fault flag
  logic [1:0]  rx_par_ff;         // received parity bits
  logic        busy_ff;           // transaction in progress
  logic        await_ff;          // waiting for acknowledge
  logic [3:0]  wait_cnt_ff;       // link clock waits counted
  logic        done_ff;           // completion pulse
  logic [15:0] adr_trace_ff;      // address trace
  logic [15:0] dat_trace_ff;      // data trace
  logic        irq_out_ff;        // error interrupt register
  logic        lclk_rise;         // link clock rising edge seen
  logic        ack_cycle;         // acknowledge cycle sampled
  logic        wait_timeout;      // wait limit exhausted
  logic        wr_take;           // write takes effect this edge
  logic        rd_take;           // read answered next edge
  logic        clr_errors;        // one written to summary flag
  logic        ev_ack_fault;      // ack fault event
  logic        ev_cancel;         // cancel event
  logic        ev_terr;           // target error event
  logic        ev_par;            // parity fault event
  logic        start_ok;          // transaction accepted for trace
  logic [7:0]  nxt_status;        // status read value
  logic [31:0] nxt_rdata;         // read mux output

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sticky flag with set winning over clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = (cur & ~clr) | set;
  endfunction

  // ---------------------------------------------------------------
  // link pin synchronisers
  // ---------------------------------------------------------------
  // two stages before any logic looks at a pin
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lclk_sync_ff <= 2'h0;
      lclk_prev_ff <= 1'h0;
      ack_sync_ff  <= 2'h0;
      err_sync_ff  <= 2'h0;
      par_meta_ff  <= 2'h0;
      par_sync_ff  <= 2'h0;
      data_meta_ff <= 8'h00;
      data_sync_ff <= 8'h00;
      irq_sync_ff  <= 2'h0;
    end
    else
    begin
      lclk_sync_ff <= {lclk_sync_ff[0], link_clk};
      lclk_prev_ff <= lclk_sync_ff[1];
      ack_sync_ff  <= {ack_sync_ff[0], link_ack};
      err_sync_ff  <= {err_sync_ff[0], link_err};
      par_meta_ff  <= link_par;
      par_sync_ff  <= par_meta_ff;
      data_meta_ff <= link_data;
      data_sync_ff <= data_meta_ff;
      irq_sync_ff  <= {irq_sync_ff[0], target_irq_pin};
    end
  end

  // edge of the sampled link clock, second stage only
  assign lclk_rise    = lclk_sync_ff[1] & ~lclk_prev_ff;
  // acknowledge sampled on a link clock rise while waiting
  assign ack_cycle    = await_ff & lclk_rise & ack_sync_ff[1];
  // no ack on this rise and the wait budget is spent
  assign wait_timeout = await_ff & lclk_rise & ~ack_sync_ff[1]
                        & (wait_cnt_ff == limit_ff);

  // ---------------------------------------------------------------
  // bus slave strobes
  // ---------------------------------------------------------------
  // a request is answered one cycle after it is seen
  assign rd_take    = avs_read & wait_ff;
  assign wr_take    = avs_write & ~wait_ff;
  assign clr_errors = wr_take & (avs_address == dlt_pkg::IDX_ERROR_STATUS)
                      & avs_byteenable[0]
                      & avs_writedata[dlt_pkg::BIT_ERROR_SUMMARY];

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_ff <= 1'h1;
    end
    else
    begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff);
    end
  end

  // ---------------------------------------------------------------
  // error events
  // ---------------------------------------------------------------
  assign ev_ack_fault = ack_cycle & (data_sync_ff != dlt_pkg::ALL_HIGH);
  assign ev_terr      = ack_cycle & err_sync_ff[1];
  assign ev_par       = ack_cycle & (par_sync_ff != seq_evt.exp_par);
  // a request during a pending error is dropped for idle
  assign ev_cancel    = seq_evt.start & err_sum_ff;
  assign start_ok     = seq_evt.start & ~err_sum_ff;

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // detail flags clear together with the summary flag
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      err_sum_ff   <= 1'h0;
      ack_fault_ff <= 1'h0;
      cancel_ff    <= 1'h0;
      timeout_ff   <= 1'h0;
      terr_ff      <= 1'h0;
      par_fault_ff <= 1'h0;
    end
    else
    begin
      err_sum_ff   <= sticky(err_sum_ff, ev_ack_fault | ev_cancel | wait_timeout
                             | ev_terr | ev_par, clr_errors);
      ack_fault_ff <= sticky(ack_fault_ff, ev_ack_fault, clr_errors);
      cancel_ff    <= sticky(cancel_ff, ev_cancel, clr_errors);
      timeout_ff   <= sticky(timeout_ff, wait_timeout, clr_errors);
      terr_ff      <= sticky(terr_ff, ev_terr, clr_errors);
      par_fault_ff <= sticky(par_fault_ff, ev_par, clr_errors);
    end
  end

  // parity as received in the acknowledge cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_par_ff <= 2'h0;
    end
    else if (ack_cycle)
    begin
      rx_par_ff <= par_sync_ff;
    end
  end

  // unmaskable error interrupt follows the summary flag
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_out_ff <= 1'h0;
    end
    else
    begin
      irq_out_ff <= err_sum_ff;
    end
  end

  // ---------------------------------------------------------------
  // wait limit control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      limit_ff <= dlt_pkg::LIMIT_RST;
    end
    else if (wr_take && avs_address == dlt_pkg::IDX_ACK_WAIT_CTRL && avs_byteenable[0])
    begin
      limit_ff <= avs_writedata[dlt_pkg::LIMIT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // busy tracking and acknowledge wait
  // ---------------------------------------------------------------
  // busy from accepted start to ack or timeout
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_ff     <= 1'h0;
      await_ff    <= 1'h0;
      wait_cnt_ff <= 4'h0;
      done_ff     <= 1'h0;
    end
    else
    begin
      done_ff <= ack_cycle | wait_timeout;
      if (start_ok)
      begin
        busy_ff <= 1'h1;
      end
      else if (ack_cycle || wait_timeout)
      begin
        busy_ff <= 1'h0;
      end
      if (seq_evt.last_xfer && busy_ff)
      begin
        await_ff    <= 1'h1;
        wait_cnt_ff <= 4'h0;
      end
      else if (ack_cycle || wait_timeout)
      begin
        await_ff <= 1'h0;
      end
      else if (await_ff && lclk_rise)
      begin
        wait_cnt_ff <= wait_cnt_ff + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // trace registers
  // ---------------------------------------------------------------
  // attributes and address captured at start, frozen under error
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      adr_trace_ff <= dlt_pkg::TRACE_RST;
    end
    else if (start_ok)
    begin
      adr_trace_ff                            <= dlt_pkg::TRACE_RST;
      adr_trace_ff[dlt_pkg::BIT_DIRECTION]    <= seq_evt.rnw;
      adr_trace_ff[dlt_pkg::BIT_BYTE_SIZE]    <= seq_evt.sz8;
      adr_trace_ff[dlt_pkg::BIT_NONBLOCKING]  <= seq_evt.nonblocking_mode_bit;
      adr_trace_ff[7:0]                       <= seq_evt.addr;
    end
  end

  // write data at start, read bytes as they arrive
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dat_trace_ff <= dlt_pkg::TRACE_RST;
    end
    else if (start_ok)
    begin
      dat_trace_ff <= seq_evt.rnw ? dlt_pkg::TRACE_RST : seq_evt.wdata;
    end
    else if (seq_evt.rd_valid && busy_ff && !err_sum_ff)
    begin
      // byte lane picked by the sequencer
      if (seq_evt.rd_hi)
      begin
        dat_trace_ff[15:8] <= seq_evt.rd_byte;
      end
      else
      begin
        dat_trace_ff[7:0] <= seq_evt.rd_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_status = dlt_pkg::STATUS_RST;
    nxt_status[dlt_pkg::BIT_ERROR_SUMMARY] = err_sum_ff;
    nxt_status[dlt_pkg::BIT_ACK_FAULT]     = ack_fault_ff;
    nxt_status[dlt_pkg::BIT_CANCEL]        = cancel_ff;
    nxt_status[dlt_pkg::BIT_TIMEOUT]       = timeout_ff;
    nxt_status[dlt_pkg::BIT_TARGET_ERROR]  = terr_ff;
    nxt_status[dlt_pkg::BIT_PARITY_FAULT]  = par_fault_ff;
    nxt_status[dlt_pkg::BIT_PARITY_HI]     = rx_par_ff[1];
    nxt_status[dlt_pkg::BIT_PARITY_LO]     = rx_par_ff[0];
    nxt_rdata = dlt_pkg::RDATA_NONE;
    // unmapped words and reserved bits read zero
    case (avs_address)
      dlt_pkg::IDX_ACK_WAIT_CTRL:
      begin
        nxt_rdata[dlt_pkg::LIMIT_W-1:0] = limit_ff;
      end
      dlt_pkg::IDX_ERROR_STATUS:
      begin
        nxt_rdata[7:0] = nxt_status;
      end
      dlt_pkg::IDX_BUSY_IRQ:
      begin
        nxt_rdata[dlt_pkg::BIT_TARGET_IRQ] = irq_sync_ff[1];
        nxt_rdata[dlt_pkg::BIT_BUSY]       = busy_ff;
      end
      dlt_pkg::IDX_ADDR_TRACE:
      begin
        nxt_rdata[15:0] = adr_trace_ff;
      end
      dlt_pkg::IDX_DATA_TRACE:
      begin
        nxt_rdata[15:0] = dat_trace_ff;
      end
      default:
      begin
        nxt_rdata = dlt_pkg::RDATA_NONE;
      end
    endcase
  end

  // read data loaded as waitrequest drops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= dlt_pkg::RDATA_NONE;
    end
    else if (rd_take)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata         = rdata_ff;
  assign avs_waitrequest      = wait_ff;
  assign link_error_interrupt = irq_out_ff;
  assign seq_rsp.hold_idle    = err_sum_ff;
  assign seq_rsp.busy         = busy_ff;
  assign seq_rsp.done         = done_ff;

endmodule
`default_nettype wire

// *** tb/dlt_status_trace_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// bus answer, sequencer and flag checks
// ---------------------------------------------
module dlt_status_trace_sva (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic [2:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_writedata,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire dlt_pkg::dlt_seq_evt_s seq_evt,
  input wire dlt_pkg::dlt_seq_rsp_s seq_rsp,
  input wire logic                  link_clk,
  input wire logic                  link_ack,
  input wire logic                  link_err,
  input wire logic [1:0]            link_par,
  input wire logic [7:0]            link_data,
  input wire logic                  target_irq_pin,
  input wire logic                  link_error_interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic       rd_ok;      // read answered now
  logic       clr_wr;     // summary clear write taken
  logic [3:0] irq_age_ff; // cycles the irq pin stood still
  assign rd_ok = avs_read && !avs_waitrequest;
  assign clr_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_writedata[7]
    && avs_address == dlt_pkg::IDX_ERROR_STATUS;
  // age of the irq pin level, saturating
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_age_ff <= 4'h0;
    else if (target_irq_pin != $past(target_irq_pin))
      irq_age_ff <= 4'h0;
    else if (irq_age_ff != 4'hf)
      irq_age_ff <= irq_age_ff + 4'h1;
  end
  AST_IRQ_LAG: assert property (1'h1 |=> link_error_interrupt
    == $past(seq_rsp.hold_idle))
    else $error("error interrupt does not follow summary flag");
  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_BUSY_START: assert property (seq_evt.start && !seq_rsp.hold_idle && !seq_rsp.busy
    |=> seq_rsp.busy)
    else $error("busy not raised by start");
  AST_CANCEL_IDLE: assert property (seq_evt.start && seq_rsp.hold_idle && !seq_rsp.busy
    |=> !seq_rsp.busy && seq_rsp.hold_idle)
    else $error("request not dropped while error pending");
  AST_SUMMARY_CLEAR: assert property ($fell(seq_rsp.hold_idle)
    |-> $past(clr_wr) || $past(clr_wr, 2))
    else $error("summary flag cleared without a one write");
  AST_DONE_PULSE: assert property (seq_rsp.done |=> !seq_rsp.done)
    else $error("done longer than one cycle");
  AST_IRQ_MIRROR: assert property (rd_ok && avs_address == dlt_pkg::IDX_BUSY_IRQ
    && irq_age_ff > 4'h8 |-> avs_readdata[7] == target_irq_pin)
    else $error("irq flag differs from pin");
  AST_BUSY_RSVD: assert property (rd_ok && avs_address == dlt_pkg::IDX_BUSY_IRQ
    |-> avs_readdata[5:0] == 6'h00 && avs_readdata[31:8] == 24'h0)
    else $error("reserved status bits not zero");
  AST_TRACE_RSVD: assert property (rd_ok && avs_address == dlt_pkg::IDX_ADDR_TRACE
    |-> avs_readdata[13] == 1'h0 && avs_readdata[11:8] == 4'h0 && avs_readdata[31:16] == 16'h0)
    else $error("reserved trace bits not zero");
  AST_UNMAPPED: assert property (rd_ok && (avs_address == 3'h0 || avs_address > 3'h5)
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // main scenarios seen
  cover property (seq_evt.start && seq_rsp.hold_idle);
  cover property ($rose(link_error_interrupt));
  cover property (seq_rsp.done);
endmodule
bind dlt_status_trace dlt_status_trace_sva i_sva (.clk, .rstn, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .seq_evt,
  .seq_rsp, .link_clk, .link_ack, .link_err, .link_par, .link_data, .target_irq_pin,
  .link_error_interrupt);
`default_nettype wire

// *** tb/dlt_target_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// companion die target: one ack frame per go
// ---------------------------------------------
module dlt_target_model (
  input  wire logic       go,
  input  wire logic [3:0] waits,
  input  wire logic       err,
  input  wire logic [1:0] par,
  input  wire logic       bad,
  input  wire logic       nack,
  input  wire logic       irq,
  output var  logic       link_clk,
  output var  logic       link_ack,
  output var  logic       link_err,
  output var  logic [1:0] link_par,
  output var  logic [7:0] link_data,
  output wire logic       target_irq_pin
);
  // only the target moves its irq pin
  assign target_irq_pin = irq;
  // link starts low, later ack rests low and the other lines keep their inverted values; clock stands still between frames
  initial
  begin
    link_clk = 1'h0;
    link_ack = 1'h0;
    link_err = 1'h0;
    link_par = 2'h0;
    link_data = 8'h00;
  end
  // wait cycles, then ack cycle with parity and error
  always @(posedge go)
  begin : frame
    int k;
    #3;
    for (k = 0; k <= int'(waits); k++)
    begin
      #70;
      if (k == int'(waits) && !nack)
      begin
        link_ack = 1'h1;
        link_err = err;
        link_par = par;
        link_data = bad ? 8'hef : 8'hff;
      end
      #10;
      link_clk = 1'h1;
      #80;
      link_clk = 1'h0;
      // released lines show no stale value
      link_ack = 1'h0;
      link_err = !link_err;
      link_par = ~link_par;
      link_data = ~link_data;
    end
  end
endmodule
`default_nettype wire

// *** tb/die_link_initiator_status_trace_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module die_link_initiator_status_trace_bench;
  // ---------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------
  logic                  clk = 1'h0;
  logic                  rstn = 1'h0;
  logic [2:0]            avs_address = 3'h0;
  logic                  avs_read = 1'h0;
  logic                  avs_write = 1'h0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  dlt_pkg::dlt_seq_evt_s seq_evt = '0;
  dlt_pkg::dlt_seq_rsp_s seq_rsp;
  logic                  link_clk, link_ack, link_err, target_irq_pin, link_error_interrupt;
  logic [1:0]            link_par;
  logic [7:0]            link_data;
  logic                  m_go = 1'h0, m_err = 1'h0, m_bad = 1'h0, m_nack = 1'h0, m_irq = 1'h0;
  logic [3:0]            m_waits = 4'h0;
  logic [1:0]            m_par = 2'h0;
  logic [31:0]           rd;
  int                    n_mismatch = 0;
  int                    comparisons = 0;
  always #4 clk = ~clk;
  dlt_status_trace i_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .seq_evt(seq_evt), .seq_rsp(seq_rsp),
    .link_clk(link_clk), .link_ack(link_ack), .link_err(link_err), .link_par(link_par),
    .link_data(link_data), .target_irq_pin(target_irq_pin),
    .link_error_interrupt(link_error_interrupt));
  dlt_target_model i_tgt (.go(m_go), .waits(m_waits), .err(m_err), .par(m_par),
    .bad(m_bad), .nack(m_nack), .irq(m_irq), .link_clk(link_clk), .link_ack(link_ack),
    .link_err(link_err), .link_par(link_par), .link_data(link_data),
    .target_irq_pin(target_irq_pin));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    end_sim;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (i = 0; i < 64; i++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'h0)
        break;
    end
    if (i == 64)
      hang;
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // one link transaction; canc: expect it dropped
  task automatic xact(input logic rnw, input logic sz8, input logic nonblocking_mode_bit, input logic [7:0] a,
    input logic [15:0] wd, input logic [15:0] rb, input logic [1:0] ep, input logic canc);
    int i;
    @(posedge clk);
    seq_evt <= '{1'h1, rnw, sz8, nonblocking_mode_bit, a, wd, 1'h0, 1'h0, 1'h0, 8'h00, ep};
    @(posedge clk);
    seq_evt.start <= 1'h0;
    if (canc)
      return;
    // read bytes arrive high lane first
    if (rnw)
    begin
      seq_evt.rd_valid <= 1'h1;
      seq_evt.rd_hi <= 1'h1;
      seq_evt.rd_byte <= rb[15:8];
      @(posedge clk);
      seq_evt.rd_hi <= 1'h0;
      seq_evt.rd_byte <= rb[7:0];
      @(posedge clk);
      seq_evt.rd_valid <= 1'h0;
    end
    seq_evt.last_xfer <= 1'h1;
    @(posedge clk);
    seq_evt.last_xfer <= 1'h0;
    rdchk(dlt_pkg::IDX_BUSY_IRQ, 32'h40);
    rdchk(dlt_pkg::IDX_DATA_TRACE, {16'h0, rnw ? rb : wd});
    @(posedge clk);
    m_go <= 1'h1;
    @(posedge clk);
    m_go <= 1'h0;
    for (i = 0; i < 600; i++)
    begin
      @(posedge clk);
      if (seq_rsp.done === 1'h1)
        break;
    end
    if (i == 600)
      hang;
    rdchk(dlt_pkg::IDX_BUSY_IRQ, 32'h0);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic s_reset;
    int k;
    for (k = 0; k < 8; k++)
      rdchk(k[2:0], 32'h0);
    bus(1'h1, dlt_pkg::IDX_ADDR_TRACE, 32'hffff_ffff);
    rdchk(dlt_pkg::IDX_ADDR_TRACE, 32'h0);
  endtask
  // clean write, ack on last allowed wait
  task automatic s_write;
    bus(1'h1, dlt_pkg::IDX_ACK_WAIT_CTRL, 32'h2);
    m_waits <= 4'h2;
    m_par <= 2'h2;
    xact(1'h0, 1'h0, 1'h0, 8'h2d, 16'hbeef, 16'h0, 2'h2, 1'h0);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'h02);
    rdchk(dlt_pkg::IDX_ADDR_TRACE, 32'h002d);
    rdchk(dlt_pkg::IDX_DATA_TRACE, 32'hbeef);
  endtask
  // read with target error and bad parity
  task automatic s_read_err;
    m_waits <= 4'h1;
    m_err <= 1'h1;
    m_par <= 2'h1;
    xact(1'h1, 1'h0, 1'h0, 8'h5a, 16'h0, 16'ha53c, 2'h2, 1'h0);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'h8d);
    rdchk(dlt_pkg::IDX_ADDR_TRACE, 32'h805a);
    rdchk(dlt_pkg::IDX_DATA_TRACE, 32'ha53c);
    chk({31'h0, link_error_interrupt}, 32'h1);
  endtask
  // request while error pending, then zero and one writes
  task automatic s_cancel;
    xact(1'h0, 1'h1, 1'h1, 8'h11, 16'h1234, 16'h0, 2'h0, 1'h1);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'had);
    rdchk(dlt_pkg::IDX_ADDR_TRACE, 32'h805a);
    rdchk(dlt_pkg::IDX_DATA_TRACE, 32'ha53c);
    bus(1'h1, dlt_pkg::IDX_ERROR_STATUS, 32'h7f);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'had);
    bus(1'h1, dlt_pkg::IDX_ERROR_STATUS, 32'h80);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'h01);
    chk({31'h0, link_error_interrupt}, 32'h0);
  endtask
  // broken data line in ack cycle, byte non-blocking write
  task automatic s_ack_fault;
    m_waits <= 4'h0;
    m_err <= 1'h0;
    m_bad <= 1'h1;
    m_par <= 2'h3;
    xact(1'h0, 1'h1, 1'h1, 8'hc3, 16'h007e, 16'h0, 2'h3, 1'h0);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'hc3);
    rdchk(dlt_pkg::IDX_ADDR_TRACE, 32'h50c3);
    rdchk(dlt_pkg::IDX_DATA_TRACE, 32'h007e);
    bus(1'h1, dlt_pkg::IDX_ERROR_STATUS, 32'h80);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'h03);
  endtask
  // limit zero, no ack at first rise
  task automatic s_timeout;
    m_bad <= 1'h0;
    m_nack <= 1'h1;
    bus(1'h1, dlt_pkg::IDX_ACK_WAIT_CTRL, 32'h0);
    xact(1'h0, 1'h0, 1'h0, 8'h01, 16'h5555, 16'h0, 2'h3, 1'h0);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'h93);
    bus(1'h1, dlt_pkg::IDX_ERROR_STATUS, 32'h80);
    rdchk(dlt_pkg::IDX_ERROR_STATUS, 32'h03);
    m_nack <= 1'h0;
  endtask
  task automatic s_irq;
    m_irq <= 1'h1;
    repeat (12) @(posedge clk);
    rdchk(dlt_pkg::IDX_BUSY_IRQ, 32'h80);
    m_irq <= 1'h0;
    repeat (12) @(posedge clk);
    rdchk(dlt_pkg::IDX_BUSY_IRQ, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    s_reset;
    s_write;
    s_read_err;
    s_cancel;
    s_ack_fault;
    s_timeout;
    s_irq;
    end_sim;
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    hang;
  end
endmodule
`default_nettype wire
